// File: pad_board.sv
// board model: resolves each pad to one level seen by the mux
// assumes: pad_oe high means the mux drives; board drives only idle pads
`timescale 1ns/1ps
module pad_board (
    input  wire logic       clk,
    input  wire logic [2:0] pad_out,
    input  wire logic [2:0] pad_oe,
    input  wire logic [2:0] pad_pull_en,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic      [2:0] pad_in
);
    logic [2:0] last_reg = 3'h0;
    // an unpulled floating pad wanders rather than keeping its last level
    always_ff @(posedge clk)
        last_reg <= pad_in;
    always_comb
        for (int i = 0; i < 3; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
                      : pad_pull_en[i] ? 1'b1 : ~last_reg[i];
endmodule // pad_board

// File: pad_mux.sv
// top of the three-pad parallel port control mux
// assumes: resetn is the reset pin already synchronous to clk; memory
// controller signals come from logic on clk; pads resolved by the testbench
`timescale 1ns/1ps
module pad_mux (
    input  wire logic        clk,
    input  wire logic        resetn,
    // strap and test pins
    input  wire logic        strap_select_pin,
    input  wire logic        test_reset_n,
    input  wire logic        emulation_pin_zero,
    input  wire logic        emulation_one_off_pin,
    // memory controller side
    input  wire logic        mem_byte_enable_two,
    input  wire logic        mem_byte_enable_three,
    input  wire logic        sdram_clock_enable_out,
    input  wire logic        mem_clock_in,
    input  wire logic        hold_request,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // pads
    input  wire logic [2:0]  pad_in,
    output logic      [2:0]  pad_out,
    output logic      [2:0]  pad_oe,
    output logic      [2:0]  pad_holder_en,
    output logic      [2:0]  pad_pull_en,
    output logic             memory_clock_out,
    output logic             memory_clock_oe,
    output logic             mem_mode
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic       strap_s;
    logic       trst_s;
    logic       emulation_pin_zero_s;
    logic       emu1_s;
    logic [2:0] pad_in_s;

    sync3 #(.RST_VAL(1'h0)) u_strap (
        .clk    (clk),
        .resetn (1'h1),
        .din    (strap_select_pin),
        .dout   (strap_s)
    );
    sync3 #(.RST_VAL(1'h1)) u_trst (
        .clk    (clk),
        .resetn (resetn),
        .din    (test_reset_n),
        .dout   (trst_s)
    );
    sync3 #(.RST_VAL(1'h0)) u_emulation_pin_zero (
        .clk    (clk),
        .resetn (resetn),
        .din    (emulation_pin_zero),
        .dout   (emulation_pin_zero_s)
    );
    sync3 #(.RST_VAL(1'h1)) u_emu1 (
        .clk    (clk),
        .resetn (resetn),
        .din    (emulation_one_off_pin),
        .dout   (emu1_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < pad_mux_pkg::NUM_PADS; gi++) begin : g_pin
            sync3 #(.RST_VAL(1'h0)) u_pin (
                .clk    (clk),
                .resetn (resetn),
                .din    (pad_in[gi]),
                .dout   (pad_in_s[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        in_reset;
        logic        mode;
        logic [2:0]  gp_dir;
        logic [2:0]  gp_out;
        logic [1:0]  bus_ctrl;
        logic        hold_clk_tz;
        logic [31:0] rdata;
        logic [2:0]  pout;
        logic [2:0]  poe;
        logic [2:0]  holder;
        logic [2:0]  pull;
        logic        mclk;
        logic        mclk_oe;
    } st_t;
    st_t st_reg;
    st_t st_next;

    logic off_mode;
    logic pads_float;

    always_comb begin
        st_next  = st_reg;
        // off mode from synchronised test pins
        off_mode = !trst_s && emulation_pin_zero_s && !emu1_s;
        // reset, hold and off mode all release the pads
        pads_float = st_reg.in_reset || hold_request || off_mode;

        st_next.in_reset = 1'h0;
        // strap taken on the first edge after reset releases, never again
        if (st_reg.in_reset) begin
            st_next.mode = strap_s;
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                pad_mux_pkg::GP_DIR_OFF:   st_next.gp_dir = reg_wdata[2:0];
                pad_mux_pkg::GP_OUT_OFF:   st_next.gp_out = reg_wdata[2:0];
                pad_mux_pkg::BUS_CTRL_OFF: st_next.bus_ctrl = reg_wdata[1:0];
                pad_mux_pkg::HOLD_CLK_OFF: st_next.hold_clk_tz = reg_wdata[0];
                default: ;
            endcase
        end

        // register reads, data valid the cycle after the strobe
        st_next.rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                pad_mux_pkg::GP_DIR_OFF:   st_next.rdata = {29'h0, st_reg.gp_dir};
                pad_mux_pkg::GP_OUT_OFF:   st_next.rdata = {29'h0, st_reg.gp_out};
                pad_mux_pkg::GP_IN_OFF:    st_next.rdata = {28'h0, st_reg.mode,
                                                            pad_in_s};
                pad_mux_pkg::BUS_CTRL_OFF: st_next.rdata = {30'h0, st_reg.bus_ctrl};
                pad_mux_pkg::HOLD_CLK_OFF: st_next.rdata = {31'h0,
                                                            st_reg.hold_clk_tz};
                default: st_next.rdata = 32'h0;
            endcase
        end

        // pad muxing from the stored strap copy
        if (st_reg.mode) begin
            st_next.pout = {sdram_clock_enable_out,
                            mem_byte_enable_three,
                            mem_byte_enable_two};
            st_next.poe  = 3'h7;
        end else begin
            st_next.pout = st_reg.gp_out;
            st_next.poe  = st_reg.gp_dir;
        end
        if (pads_float) begin
            st_next.poe = 3'h0;
        end

        // memory clock only exists in memory mode; floats in hold if asked
        st_next.mclk    = mem_clock_in;
        st_next.mclk_oe = st_reg.mode && !st_reg.in_reset && !off_mode
                          && !(hold_request && st_reg.hold_clk_tz);

        st_next.holder = {3{st_reg.bus_ctrl[pad_mux_pkg::HOLDER_EN_BIT]}};
        st_next.pull   = {3{st_reg.bus_ctrl[pad_mux_pkg::PULL_EN_BIT]}};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg             <= '0;
            st_reg.in_reset    <= 1'h1;
            st_reg.gp_dir      <= pad_mux_pkg::GP_DIR_RST;
            st_reg.gp_out      <= pad_mux_pkg::GP_OUT_RST;
            st_reg.bus_ctrl    <= pad_mux_pkg::BUS_CTRL_RST;
            st_reg.hold_clk_tz <= pad_mux_pkg::HOLD_CLK_RST;
            st_reg.pout        <= {3{pad_mux_pkg::MEM_IDLE_LEVEL}};
            st_reg.holder      <= 3'h7;
            st_reg.pull        <= 3'h7;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata        = st_reg.rdata;
    assign pad_out          = st_reg.pout;
    assign pad_oe           = st_reg.poe;
    assign pad_holder_en    = st_reg.holder;
    assign pad_pull_en      = st_reg.pull;
    assign memory_clock_out = st_reg.mclk;
    assign memory_clock_oe  = st_reg.mclk_oe;
    assign mem_mode         = st_reg.mode;
endmodule // pad_mux

// File: pad_mux_pkg.sv
// package: register map, field positions, reset values for the pad mux
// assumes: single 200 MHz clock domain, plain strobe register port
package pad_mux_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          NUM_PADS       = 3;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0]  GP_DIR_OFF     = 4'h0;
    localparam logic [3:0]  GP_OUT_OFF     = 4'h4;
    localparam logic [3:0]  GP_IN_OFF      = 4'h8;
    localparam logic [3:0]  BUS_CTRL_OFF   = 4'hc;
    localparam logic [3:0]  HOLD_CLK_OFF   = 4'h2;
    // ----------------------------------------------------------------
    // external bus control fields
    // ----------------------------------------------------------------
    localparam int          HOLDER_EN_BIT  = 0;
    localparam int          PULL_EN_BIT    = 1;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  GP_DIR_RST     = 3'h0;
    localparam logic [2:0]  GP_OUT_RST     = 3'h0;
    localparam logic [1:0]  BUS_CTRL_RST   = 2'h3;
    localparam logic        HOLD_CLK_RST   = 1'h0;
    localparam logic        MEM_IDLE_LEVEL = 1'h1;
endpackage

// File: pad_mux_sva.sv
// checker: pad behaviour of the pad mux seen at its top ports
// assumes: one clock domain, resetn synchronous and active low
`timescale 1ns/1ps
module pad_mux_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        test_reset_n,
    input wire logic        emulation_pin_zero,
    input wire logic        emulation_one_off_pin,
    input wire logic        mem_byte_enable_two,
    input wire logic        mem_byte_enable_three,
    input wire logic        sdram_clock_enable_out,
    input wire logic        hold_request,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  pad_out,
    input wire logic [2:0]  pad_oe,
    input wire logic [2:0]  pad_holder_en,
    input wire logic [2:0]  pad_pull_en,
    input wire logic        memory_clock_oe,
    input wire logic        mem_mode
);
    // ---
    // pad rules
    // ---
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // off mode passes three sync stages, the sync output register and the pad
    // register, so a pin change shows on the pads only at the sixth sample
    wire logic off_in = !test_reset_n && emulation_pin_zero
                        && !emulation_one_off_pin;
    sequence off_s; off_in [*6]; endsequence
    sequence quiet_s; !off_in [*6]; endsequence
    sequence hold_s; hold_request [*2]; endsequence
    reset_float_a: assert property (disable iff (1'b0)
        !resetn |=> pad_oe == 3'h0 && !memory_clock_oe)
        else $error("pads driven in reset");
    holder_default_a: assert property (disable iff (1'b0)
        !resetn |=> pad_holder_en == 3'h7 && pad_pull_en == 3'h7)
        else $error("holder or pull off after reset");
    hold_float_a: assert property (hold_s |-> pad_oe == 3'h0)
        else $error("pads driven in hold");
    strap_freeze_a: assert property (resetn [*3] |-> $stable(mem_mode))
        else $error("mode moved after reset");
    mem_drive_a: assert property (quiet_s ##0 (mem_mode && $past(mem_mode)
        && !$past(hold_request)) |-> pad_oe == 3'h7 && pad_out == $past(
        {sdram_clock_enable_out, mem_byte_enable_three, mem_byte_enable_two}))
        else $error("memory controls not on pads");
    gp_input_a: assert property ($rose(resetn) ##2 !mem_mode
        |-> pad_oe == 3'h0)
        else $error("gp line not input after reset");
    off_float_a: assert property (off_s
        |-> pad_oe == 3'h0 && !memory_clock_oe)
        else $error("pads driven in off mode");
    mode_readback_a: assert property (reg_rd
        && reg_addr == pad_mux_pkg::GP_IN_OFF
        |=> reg_rdata[3] == mem_mode)
        else $error("mode bit differs from stored strap");
endmodule // pad_mux_sva
bind pad_mux pad_mux_sva chk_u (.*);

// File: sync3.sv
// three-stage synchroniser for pin inputs
// assumes: input asynchronous to clk; output changes when stages 2 and 3 agree
`timescale 1ns/1ps
module sync3 #(
    parameter logic RST_VAL = 1'h0
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } st_t;
    st_t st_reg;
    st_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule // sync3

// File: tb_top.sv
// testbench: gp and memory modes, hold, off mode, register port
// assumes: pad_board resolves the pads; checker is bound to the mux
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, strap_select_pin = 1'b0;
    logic test_reset_n = 1'b1, emulation_pin_zero = 1'b0;
    logic emulation_one_off_pin = 1'b1, mem_byte_enable_two = 1'b1;
    logic mem_byte_enable_three = 1'b1, sdram_clock_enable_out = 1'b1;
    logic mem_clock_in = 1'b0, hold_request = 1'b0, reg_wr = 1'b0;
    logic reg_rd = 1'b0, memory_clock_out, memory_clock_oe, mem_mode, c;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [2:0] pad_in, pad_out, pad_oe, pad_holder_en, pad_pull_en;
    logic [2:0] ext_en = 3'h0, ext_val = 3'h0, dir, val, ext;
    int failures = 0, checks_done = 0, seed = 32'h293e6882;
    pad_mux dut_u (.*);
    pad_board board_u (.*);
    always #2.5 clk = ~clk;
    always @(posedge clk) mem_clock_in <= ~mem_clock_in;
    // ---
    // tasks
    // ---
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // driven pads read back their own level, the rest the board's level
    function automatic logic [31:0] gp_in_exp(logic [2:0] v, logic [2:0] dr,
                                              logic [2:0] x);
        return {29'h0, (v & dr) | (x & ~dr)};
    endfunction
    task automatic results();
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_n(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(logic s);
        @(posedge clk);
        resetn <= 1'b0;
        strap_select_pin <= s;
        wait_n(16);
        chk("oe_in_reset", 3'h0, pad_oe);
        @(posedge clk);
        resetn <= 1'b1;
        wait_n(3);
        chk("mode", s, mem_mode);
        chk("holder", 3'h7, pad_holder_en);
        chk("pull", 3'h7, pad_pull_en);
    endtask
    // the whole run needs about two hundred cycles; this is far beyond it
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        do_reset(1'b0);
        chk("gp_oe", 3'h0, pad_oe);
        rd(4'hf);
        chk("unmapped", 32'h0, d);
        for (int i = 0; i < 6; i++) begin
            dir = i == 0 ? 3'h7 : i == 1 ? 3'h0 : 3'($random(seed));
            val = 3'($random(seed));
            ext = 3'($random(seed));
            @(posedge clk);
            ext_en <= ~dir;
            ext_val <= ext;
            strap_select_pin <= ~strap_select_pin;
            wr(4'h0, {29'h0, dir});
            wr(4'h4, {29'h0, val});
            wait_n(6);
            chk("gp_oe", dir, pad_oe);
            chk("gp_out", val, pad_out);
            rd(4'h8);
            chk("gp_in", gp_in_exp(val, dir, ext), d);
            rd(pad_mux_pkg::GP_DIR_OFF);
            chk("gp_dir_rd", {29'h0, dir}, d);
            rd(pad_mux_pkg::GP_OUT_OFF);
            chk("gp_out_rd", {29'h0, val}, d);
        end
        wr(4'hc, 32'h0);
        wait_n(2);
        chk("holder_off", 3'h0, pad_holder_en);
        chk("pull_off", 3'h0, pad_pull_en);
        rd(pad_mux_pkg::BUS_CTRL_OFF);
        chk("bus_ctrl_rd", 32'h0, d);
        do_reset(1'b1);
        chk("mem_idle", 6'h3f, {pad_oe, pad_out});
        for (int i = 0; i < 8; i++) begin
            dir = 3'($random(seed));
            @(posedge clk);
            {sdram_clock_enable_out, mem_byte_enable_three,
             mem_byte_enable_two} <= dir;
            strap_select_pin <= dir[0];
            wait_n(2);
            chk("mem_pads", {3'h7, dir}, {pad_oe, pad_out});
        end
        chk("strap_kept", 1'b1, mem_mode);
        rd(pad_mux_pkg::GP_IN_OFF);
        chk("mode_bit", 1'b1, d[3]);
        @(posedge clk);
        hold_request <= 1'b1;
        wait_n(3);
        chk("hold_oe", 3'h0, pad_oe);
        c = memory_clock_out;
        wait_n(1);
        chk("clk_runs", {2'h3, !c}, {memory_clock_oe, 1'b1, memory_clock_out});
        wr(4'h2, 32'h1);
        wait_n(2);
        chk("clk_float", 1'b0, memory_clock_oe);
        rd(pad_mux_pkg::HOLD_CLK_OFF);
        chk("tz_rd", 32'h1, d);
        @(posedge clk);
        hold_request <= 1'b0;
        test_reset_n <= 1'b0;
        emulation_pin_zero <= 1'b1;
        emulation_one_off_pin <= 1'b0;
        wait_n(8);
        chk("off_oe", 3'h0, pad_oe);
        @(posedge clk);
        test_reset_n <= 1'b1;
        wait_n(8);
        chk("off_end", 3'h7, pad_oe);
        results();
    end
endmodule // tb_top
